// file: tb/adcpd_host_model.sv
// Host model: drives shift clock and power-down pin of the converter
`timescale 1ns/1ps
module adcpd_host_model #(
    parameter int P_HALF = 4,
    parameter int P_PD_LOW = 2600
) (
    // Clock and link in
    input wire logic i_clk,
    input wire logic i_ready_data_out,
    // Host pins
    output logic o_sclk,
    output logic o_power_down_n,
    output logic o_framing
);
    initial begin
        o_sclk = 1'b0;
        o_power_down_n = 1'b0;
        o_framing = 1'b0;
    end
    // Bit sampled just before the next rise, long after it has settled
    task automatic shift(input int n, output logic [23:0] w);
        w = 24'h000000;
        o_framing = 1'b1;
        for (int i = 1; i <= n; i++) begin
            o_sclk = 1'b1;
            repeat (P_HALF) @(negedge i_clk);
            o_sclk = 1'b0;
            repeat (P_HALF - 1) @(negedge i_clk);
            if (i <= 24) w = {w[22:0], i_ready_data_out};
            @(negedge i_clk);
        end
        repeat (8) @(negedge i_clk);
        o_framing = 1'b0;
    endtask
    task automatic set_sclk(input logic v);
        o_sclk = v;
    endtask
    task automatic release_pd();
        o_power_down_n = 1'b1;
    endtask
    // Shift clock parked low so the wake after release is clean
    task automatic pd_pulse();
        o_sclk = 1'b0;
        o_power_down_n = 1'b0;
        repeat (P_PD_LOW) @(negedge i_clk);
        o_power_down_n = 1'b1;
    endtask
endmodule // adcpd_host_model

// file: tb/testbench.sv
// Testbench: power-mode control of the converter against a host model
`timescale 1ns/1ps
module testbench;
    import adcpd_pkg::*;
    // --------------------
    // Setup
    // --------------------
    localparam int CONV_F = 120;
    localparam int CONV_S = 180;
    localparam int STBY_F = 60;
    localparam int STBY_S = 90;
    localparam int SWAKE_F = 130;
    localparam int SWAKE_S = 190;
    localparam int SCAL_F = 150;
    localparam int SCAL_S = 210;
    localparam int CAL_F = 140;
    localparam int CAL_S = 200;
    localparam int WAKE_X = 50;
    // 7.95 us and 0.16 us in whole converter periods
    localparam int WAKE_I = 40;
    localparam int WAKE_E = 1;
    typedef struct {string name; int lo; int hi;} adcpd_note_s;
    logic clk, rst, sclk, pdn, rate, framing;
    logic [1:0] src;
    logic [WORD_W-1:0] word, got;
    logic rdy, analog_on, clock_on, standby, cal_active;
    logic [31:0] seed;
    int cyc, last_fall, base, failures, total_checks;
    adcpd_note_s notes[$];
    adcpd_note_s nt;

    adcpd_ctrl #(.P_CONV_FAST(CONV_F), .P_CONV_SLOW(CONV_S), .P_STBY_FAST(STBY_F), .P_STBY_SLOW(STBY_S),
        .P_SWAKE_FAST(SWAKE_F), .P_SWAKE_SLOW(SWAKE_S), .P_SCAL_FAST(SCAL_F), .P_SCAL_SLOW(SCAL_S),
        .P_CAL_FAST(CAL_F), .P_CAL_SLOW(CAL_S), .P_WAKE_XTAL(WAKE_X)) dut (
        .i_clk(clk), .i_rst(rst), .i_sclk(sclk), .i_power_down_n(pdn), .i_rate_sel(rate),
        .i_clk_src(src), .i_conv_word(word), .o_ready_data_out(rdy), .o_analog_on(analog_on),
        .o_clock_on(clock_on), .o_standby(standby), .o_cal_active(cal_active));
    adcpd_host_model host (.i_clk(clk), .i_ready_data_out(rdy), .o_sclk(sclk), .o_power_down_n(pdn),
        .o_framing(framing));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(negedge clk) cyc <= cyc + 1;
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        $display("FAIL watchdog expected end seen none");
        print_verdict();
    end
    // --------------------
    // Checking
    // --------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic int tk(input int n);
        return n * int'(PHASE_MOD) / int'(PHASE_INC);
    endfunction
    function automatic int wk(input logic [1:0] s);
        return (s == CLKSRC_EXT) ? WAKE_E : (s == CLKSRC_XTAL) ? WAKE_X : WAKE_I;
    endfunction
    task automatic check_val(input string nm, input logic [23:0] exp, input logic [23:0] act);
        total_checks++;
        if (act !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", nm, exp, act);
        end
    endtask
    task automatic check_time(input string nm, input int lo, input int hi, input int act);
        total_checks++;
        if (act < lo || act > hi) begin
            failures++;
            $display("FAIL %s expected cycle %0d..%0d seen %0d", nm, lo, hi, act);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic expect_at(input string nm, input int b, input int n);
        notes.push_back('{nm, b + tk(n) - 25, b + tk(n) + 12});
    endtask
    // Falls inside a readout are data bits, not announcements
    always @(negedge rdy) begin
        if (!framing) begin
            last_fall = cyc;
            if (notes.size() > 0) begin
                nt = notes.pop_front();
                check_time(nt.name, nt.lo, nt.hi, cyc);
            end
        end
    end
    task automatic wait_for(input int which);
        int n;
        n = 0;
        while (!((which == 0 && rdy === 1'b0 && !framing) || (which == 1 && standby === 1'b1) ||
                 (which == 2 && cal_active === 1'b1))) begin
            @(negedge clk);
            n++;
            if (n > 20000) begin
                failures++;
                $display("FAIL wait %0d expected event seen none", which);
                print_verdict();
            end
        end
    endtask
    task automatic next_word();
        seed = xs(seed);
        word = seed[23:0];
    endtask
    task automatic read_check();
        host.shift(25, got);
        check_val("word", word, got);
        check_val("pin after 25th", 24'h1, {23'h0, rdy});
        next_word();
    endtask
    task automatic enter_standby(input int n);
        base = cyc;
        host.set_sclk(1'b1);
        wait_for(1);
        check_time("standby entry", base + tk(n) - 25, base + tk(n) + 12, cyc);
        check_val("standby outputs", 24'h5, {21'h0, clock_on, analog_on, rdy});
    endtask
    // --------------------
    // Scenarios
    // --------------------
    initial begin
        rst = 1'b1;
        rate = 1'b1;
        src = CLKSRC_INT;
        word = 24'h000000;
        seed = 32'hd3894ae3;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        next_word();
        expect_at("first result", cyc, WAKE_I + CONV_F);
        host.release_pd();
        wait_for(0);
        read_check();
        $display("test power_up done");
        expect_at("conv period", last_fall, CONV_F);
        wait_for(0);
        enter_standby(STBY_F);
        repeat (50) @(negedge clk);
        expect_at("standby wake", cyc, SWAKE_F);
        host.set_sclk(1'b0);
        wait_for(0);
        read_check();
        $display("test standby done");
        for (int k = 0; k < 3; k++) begin
            wait_for(0);
            if (k == 0) begin
                host.shift(10, got);
            end else if (k == 1) begin
                host.shift(26, got);
                wait_for(2);
            end else begin
                read_check();
                enter_standby(STBY_F);
            end
            fork
                host.pd_pulse();
                begin
                    repeat (20) @(negedge clk);
                    check_val("pd outputs", 24'h10, {19'h0, rdy, clock_on, analog_on, standby, cal_active});
                    src = k[1:0];
                    rate = (k != 2);
                end
            join
            expect_at("pd wake", cyc, wk(src) + (rate ? CONV_F : CONV_S));
            wait_for(0);
            check_val("cal dropped", 24'h0, {23'h0, cal_active});
            read_check();
            wait_for(0);
            read_check();
            enter_standby(rate ? STBY_F : STBY_S);
            repeat (50) @(negedge clk);
            expect_at("cal wake", cyc, rate ? SCAL_F : SCAL_S);
            host.set_sclk(1'b0);
            repeat (10) @(negedge clk);
            check_val("cal start", 24'h2, {22'h0, cal_active, standby});
            wait_for(0);
            read_check();
            $display("test power_down %0d done", k);
        end
        check_val("notes left", 24'h0, 24'(notes.size()));
        print_verdict();
    end
endmodule // testbench

// file: verilog/adcpd_ctrl.sv
// Module: standby, calibration and power-down control of the converter
// ------------------------------------------------------------
// What this block does
// - Standby with calibration queued starts offset calibration right at wake-up.
// - First data ready 103 ms (fast rate) or 803 ms (slow) after such wake.
// - First result after standby with calibration is settled and delivered at once.
// - All timings are fixed counts of converter clock periods.
// - Power-down pin low shuts all circuitry; host holds each low pulse 26 us.
// - Power-down resets all state, partial readout and pending calibration included.
// - Power-down is taken mid-readout and the readout is abandoned.
// - Wake time after power-down: 7.95 us internal, 0.16 us external, 5.6 ms crystal.
// - Shift clock high after data ready for 12.46 or 99.96 ms enters standby.
// - Shift clock falling wakes the device to conversion or queued calibration.
// - The 25th shift pulse after a data word drives ready/data high.
// - A new result is announced by driving ready/data low.
// ------------------------------------------------------------
`timescale 1ns/1ps
module adcpd_ctrl #(
    parameter int unsigned P_CONV_FAST = int'(adcpd_pkg::TK_CONV_FAST),
    parameter int unsigned P_CONV_SLOW = int'(adcpd_pkg::TK_CONV_SLOW),
    parameter int unsigned P_STBY_FAST = int'(adcpd_pkg::TK_STBY_FAST),
    parameter int unsigned P_STBY_SLOW = int'(adcpd_pkg::TK_STBY_SLOW),
    parameter int unsigned P_SWAKE_FAST = int'(adcpd_pkg::TK_SWAKE_FAST),
    parameter int unsigned P_SWAKE_SLOW = int'(adcpd_pkg::TK_SWAKE_SLOW),
    parameter int unsigned P_SCAL_FAST = int'(adcpd_pkg::TK_SCAL_FAST),
    parameter int unsigned P_SCAL_SLOW = int'(adcpd_pkg::TK_SCAL_SLOW),
    parameter int unsigned P_CAL_FAST = int'(adcpd_pkg::TK_CAL_FAST),
    parameter int unsigned P_CAL_SLOW = int'(adcpd_pkg::TK_CAL_SLOW),
    parameter int unsigned P_WAKE_XTAL = int'(adcpd_pkg::TK_WAKE_XTAL)
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Host pins
    input wire logic i_sclk,
    input wire logic i_power_down_n,
    input wire logic i_rate_sel,
    input wire logic [1:0] i_clk_src,
    // Converter core result
    input wire logic [adcpd_pkg::WORD_W-1:0] i_conv_word,
    // Pin and power state outputs
    output logic o_ready_data_out,
    output logic o_analog_on,
    output logic o_clock_on,
    output logic o_standby,
    output logic o_cal_active
);
    import adcpd_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers and edges
    // ------------------------------------------------------------
    logic [4:0] meta_r;
    logic [4:0] sync_r;
    logic sclk_d_r;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_r <= 5'h00;
            sync_r <= 5'h00;
            sclk_d_r <= 1'b0;
        end else begin
            meta_r <= {i_clk_src, i_rate_sel, i_power_down_n, i_sclk};
            sync_r <= meta_r;
            sclk_d_r <= sync_r[0];
        end
    end
    wire sclk_s = sync_r[0];
    wire pdn_s = sync_r[1];
    wire rate_s = sync_r[2];
    wire [1:0] src_s = sync_r[4:3];
    wire sclk_rise = sclk_s && !sclk_d_r;
    wire sclk_fall = !sclk_s && sclk_d_r;

    logic tick;
    adcpd_tick_div u_div (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .o_tick(tick)
    );

    function automatic adcpd_cnt_t pick(input logic fast, input int unsigned f, input int unsigned s);
        return fast ? adcpd_cnt_t'(f) : adcpd_cnt_t'(s);
    endfunction

    // ------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------
    adcpd_state_e state_r;
    adcpd_state_e state_nxt;
    adcpd_cnt_t cnt_r;
    adcpd_cnt_t stby_cnt_r;
    adcpd_bit_t bit_r;
    logic [WORD_W-1:0] shift_r;
    logic have_data_r;
    logic cal_q_r;

    wire cnt_zero = (cnt_r == '0);
    wire cnt_done = tick && cnt_zero;
    wire cal_cmd = sclk_fall && (bit_r == BIT_CAL);
    wire adcpd_cnt_t stby_tgt = pick(rate_s, P_STBY_FAST, P_STBY_SLOW);
    wire stby_arm = (state_r == S_CONV) && sclk_s && have_data_r;
    wire stby_hit = stby_arm && tick && (stby_cnt_r == stby_tgt - 1'b1);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            S_OFF: if (pdn_s) state_nxt = S_WAKE;
            S_WAKE: if (cnt_done) state_nxt = S_CONV;
            S_CONV: begin
                if (stby_hit) begin
                    state_nxt = S_STANDBY;
                end else if (cal_cmd) begin
                    state_nxt = S_CAL;
                end
            end
            S_CAL: if (cnt_done) state_nxt = S_CONV;
            S_STANDBY: if (sclk_fall) state_nxt = cal_q_r ? S_CAL : S_CONV;
            default: state_nxt = S_OFF;
        endcase
        if (!pdn_s) state_nxt = S_OFF;
    end

    // ------------------------------------------------------------
    // Interval counter selection
    // ------------------------------------------------------------
    wire adcpd_cnt_t wake_tk = (src_s == CLKSRC_XTAL) ? adcpd_cnt_t'(P_WAKE_XTAL) :
        (src_s == CLKSRC_EXT) ? TK_WAKE_EXT : TK_WAKE_INT;
    wire from_stby = (state_r == S_STANDBY);
    wire adcpd_cnt_t cal_tk = from_stby ? pick(rate_s, P_SCAL_FAST, P_SCAL_SLOW) :
        pick(rate_s, P_CAL_FAST, P_CAL_SLOW);
    wire adcpd_cnt_t conv_tk = from_stby ? pick(rate_s, P_SWAKE_FAST, P_SWAKE_SLOW) :
        pick(rate_s, P_CONV_FAST, P_CONV_SLOW);
    wire adcpd_cnt_t load_val = (state_nxt == S_WAKE) ? wake_tk :
        (state_nxt == S_CAL) ? cal_tk : conv_tk;
    wire conv_evt = (state_r == S_CONV) && cnt_done && (state_nxt == S_CONV);
    wire cal_evt = (state_r == S_CAL) && (state_nxt == S_CONV);
    wire result_evt = conv_evt || cal_evt;
    wire cnt_load = ((state_nxt != state_r) && (state_nxt != S_OFF) && (state_nxt != S_STANDBY)) || conv_evt;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_r <= S_OFF;
            cnt_r <= '0;
            stby_cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            if (cnt_load) begin
                cnt_r <= load_val - 1'b1;
            end else if (tick && !cnt_zero) begin
                cnt_r <= cnt_r - 1'b1;
            end
            if (!stby_arm) begin
                stby_cnt_r <= '0;
            end else if (tick) begin
                stby_cnt_r <= stby_cnt_r + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Readout and ready/data pin
    // ------------------------------------------------------------
    wire shifting = (state_r == S_CONV) && sclk_rise;
    wire leave_conv = (state_nxt == S_STANDBY) || (state_nxt == S_CAL);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_ready_data_out <= 1'b1;
            shift_r <= '0;
            bit_r <= BIT_NONE;
            have_data_r <= 1'b0;
            cal_q_r <= 1'b0;
        end else if (!pdn_s) begin
            // Readout or queued calibration dies with the power-down
            o_ready_data_out <= 1'b1;
            shift_r <= '0;
            bit_r <= BIT_NONE;
            have_data_r <= 1'b0;
            cal_q_r <= 1'b0;
        end else if (result_evt) begin
            // Word after calibration is settled: no conversions to discard
            shift_r <= i_conv_word;
            o_ready_data_out <= 1'b0;
            bit_r <= BIT_NONE;
            have_data_r <= 1'b1;
            cal_q_r <= 1'b0;
        end else if (state_r == S_CONV && leave_conv) begin
            o_ready_data_out <= 1'b1;
            have_data_r <= 1'b0;
            // The standby hold is itself a rising edge, so 25 pulses leave the count one past forced-high
            cal_q_r <= (state_nxt == S_STANDBY) && (bit_r == BIT_CAL);
        end else if (shifting) begin
            if (bit_r < BIT_LAST) begin
                o_ready_data_out <= shift_r[WORD_W-1];
                shift_r <= {shift_r[WORD_W-2:0], 1'b0};
                bit_r <= bit_r + BIT_ONE;
            end else if (bit_r == BIT_LAST) begin
                o_ready_data_out <= 1'b1;
                bit_r <= BIT_FORCE;
            end else begin
                bit_r <= BIT_CAL;
            end
        end
    end

    // Power state decode; analog stays off until wake-up time is over
    assign o_analog_on = (state_r == S_CONV) || (state_r == S_CAL);
    assign o_clock_on = (state_r != S_OFF);
    assign o_standby = (state_r == S_STANDBY);
    assign o_cal_active = (state_r == S_CAL);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_pd_shuts_off: assert property (!pdn_s |=> (state_r == S_OFF) && !o_analog_on && o_ready_data_out)
        else $error("power-down did not shut the converter off");
    a_pd_clears_state: assert property (!pdn_s |=> (bit_r == BIT_NONE) && !cal_q_r && !have_data_r)
        else $error("power-down left internal state behind");
    a_pd_mid_readout: assert property ((bit_r != BIT_NONE) && (bit_r < BIT_LAST) && !pdn_s
        |=> o_ready_data_out && (bit_r == BIT_NONE))
        else $error("readout not abandoned on power-down");
    a_wake_count: assert property ((state_r == S_OFF) && pdn_s
        |=> (state_r == S_WAKE) && (cnt_r == $past(wake_tk) - 1'b1))
        else $error("wake-up interval loaded wrong");
    a_wake_ready_high: assert property ((state_r == S_WAKE) |-> o_ready_data_out && !o_analog_on)
        else $error("ready low before first result after power-down");
    a_cal_on_wake: assert property ((state_r == S_STANDBY) && cal_q_r && sclk_fall && pdn_s
        |=> (state_r == S_CAL) && (cnt_r == $past(cal_tk) - 1'b1))
        else $error("queued calibration not started at wake-up");
    a_cal_time: assert property ((state_r == S_STANDBY) && cal_q_r && sclk_fall && pdn_s
        |=> (cnt_r == ($past(rate_s) ? adcpd_cnt_t'(P_SCAL_FAST) : adcpd_cnt_t'(P_SCAL_SLOW)) - 1'b1))
        else $error("standby calibration interval wrong");
    a_cal_result: assert property ((state_r == S_CAL) && cnt_done && pdn_s
        |=> !o_ready_data_out && (state_r == S_CONV) && (bit_r == BIT_NONE))
        else $error("calibration end did not deliver a result");
    a_result_low: assert property (conv_evt && pdn_s |=> !o_ready_data_out && have_data_r)
        else $error("new result not announced");
    a_bit25_high: assert property (shifting && (bit_r == BIT_LAST) && pdn_s && !leave_conv && !result_evt
        |=> o_ready_data_out ##1 (o_ready_data_out || bit_r == BIT_NONE))
        else $error("25th shift pulse did not force ready high");
    a_standby_entry: assert property (stby_hit && pdn_s |=> o_standby && o_ready_data_out && !o_analog_on)
        else $error("standby not entered after hold time");
    a_cal_queued: assert property (stby_hit && (bit_r == BIT_CAL) && pdn_s |=> o_standby && cal_q_r)
        else $error("25 pulses before standby did not queue calibration");
    a_standby_wake: assert property (o_standby && sclk_fall && pdn_s |=> !o_standby && o_analog_on)
        else $error("falling shift clock did not wake from standby");

    c_stby_cal: cover property ((state_r == S_STANDBY) && cal_q_r ##1 (state_r == S_CAL));
    c_stby_plain: cover property ((state_r == S_STANDBY) && !cal_q_r ##1 (state_r == S_CONV));
    c_pd_readout: cover property ((bit_r != BIT_NONE) && (bit_r < BIT_LAST) && !pdn_s);
    c_cal_26th: cover property ((state_r == S_CONV) && cal_cmd);

endmodule // adcpd_ctrl

// file: verilog/adcpd_pkg.sv
// Package: constants, types and timing counts of the converter power-mode control
package adcpd_pkg;

    // ------------------------------------------------------------
    // Widths and types
    // ------------------------------------------------------------
    localparam int CNT_W = 23;
    localparam int WORD_W = 24;
    localparam int BIT_W = 5;
    localparam int PHASE_W = 21;
    typedef logic [CNT_W-1:0] adcpd_cnt_t;
    typedef logic [BIT_W-1:0] adcpd_bit_t;
    typedef logic [PHASE_W-1:0] adcpd_phase_t;
    typedef enum logic [2:0] {S_OFF, S_WAKE, S_CONV, S_CAL, S_STANDBY} adcpd_state_e;

    // ------------------------------------------------------------
    // Clock source strap and readout bit positions
    // ------------------------------------------------------------
    localparam logic [1:0] CLKSRC_INT = 2'h0;
    localparam logic [1:0] CLKSRC_EXT = 2'h1;
    localparam logic [1:0] CLKSRC_XTAL = 2'h2;
    localparam adcpd_bit_t BIT_LAST = 5'h18;
    localparam adcpd_bit_t BIT_FORCE = 5'h19;
    localparam adcpd_bit_t BIT_CAL = 5'h1a;
    localparam adcpd_bit_t BIT_ONE = 5'h01;
    localparam adcpd_bit_t BIT_NONE = 5'h00;

    // ------------------------------------------------------------
    // Converter clock: 4.9152 MHz as a phase step of the 100 MHz clock
    // ------------------------------------------------------------
    localparam longint FCLK_HZ = 64'd4915200;
    localparam longint SYS_HZ = 64'd100000000;
    localparam adcpd_phase_t PHASE_INC = 21'h00c000;
    localparam adcpd_phase_t PHASE_MOD = 21'h0f4240;

    // ------------------------------------------------------------
    // Times in ns at the nominal converter clock
    // ------------------------------------------------------------
    localparam longint T_CONV_FAST_NS = 64'd12500000;
    localparam longint T_CONV_SLOW_NS = 64'd100000000;
    localparam longint T_STBY_FAST_NS = 64'd12460000;
    localparam longint T_STBY_SLOW_NS = 64'd99960000;
    localparam longint T_SWAKE_FAST_NS = 64'd52510000;
    localparam longint T_SWAKE_SLOW_NS = 64'd401800000;
    localparam longint T_SCAL_FAST_NS = 64'd103000000;
    localparam longint T_SCAL_SLOW_NS = 64'd803000000;
    localparam longint T_CAL_FAST_NS = 64'd101280000;
    localparam longint T_CAL_SLOW_NS = 64'd801020000;
    localparam longint T_WAKE_INT_NS = 64'd7950;
    localparam longint T_WAKE_EXT_NS = 64'd160;
    localparam longint T_WAKE_XTAL_NS = 64'd5600000;

    // Whole converter clock periods, rounded up, at least one
    function automatic longint ticks_of(input longint ns);
        longint t;
        t = (ns * FCLK_HZ + 64'd999999999) / 64'd1000000000;
        return (t < 64'd1) ? 64'd1 : t;
    endfunction

    localparam longint TK_CONV_FAST = ticks_of(T_CONV_FAST_NS);
    localparam longint TK_CONV_SLOW = ticks_of(T_CONV_SLOW_NS);
    localparam longint TK_STBY_FAST = ticks_of(T_STBY_FAST_NS);
    localparam longint TK_STBY_SLOW = ticks_of(T_STBY_SLOW_NS);
    localparam longint TK_SWAKE_FAST = ticks_of(T_SWAKE_FAST_NS);
    localparam longint TK_SWAKE_SLOW = ticks_of(T_SWAKE_SLOW_NS);
    localparam longint TK_SCAL_FAST = ticks_of(T_SCAL_FAST_NS);
    localparam longint TK_SCAL_SLOW = ticks_of(T_SCAL_SLOW_NS);
    localparam longint TK_CAL_FAST = ticks_of(T_CAL_FAST_NS);
    localparam longint TK_CAL_SLOW = ticks_of(T_CAL_SLOW_NS);
    localparam longint TK_WAKE_XTAL = ticks_of(T_WAKE_XTAL_NS);
    localparam adcpd_cnt_t TK_WAKE_INT = adcpd_cnt_t'(ticks_of(T_WAKE_INT_NS));
    localparam adcpd_cnt_t TK_WAKE_EXT = adcpd_cnt_t'(ticks_of(T_WAKE_EXT_NS));

endpackage

// file: verilog/adcpd_tick_div.sv
// Module: fractional divider making the converter clock enable
`timescale 1ns/1ps
module adcpd_tick_div #(
    parameter adcpd_pkg::adcpd_phase_t P_INC = adcpd_pkg::PHASE_INC,
    parameter adcpd_pkg::adcpd_phase_t P_MOD = adcpd_pkg::PHASE_MOD
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Converter clock enable
    output logic o_tick
);
    import adcpd_pkg::*;

    adcpd_phase_t acc_r;
    wire adcpd_phase_t sum = acc_r + P_INC;
    wire wrap = (sum >= P_MOD);
    // Phase accumulator keeps the long-run rate exact, so every count stays a count of converter periods
    wire adcpd_phase_t acc_nxt = wrap ? (sum - P_MOD) : sum;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            acc_r <= '0;
            o_tick <= 1'b0;
        end else begin
            acc_r <= acc_nxt;
            o_tick <= wrap;
        end
    end

endmodule // adcpd_tick_div
